//--- verilog/wdt_pkg.sv
// Package with register map, field positions and reset values of the watchdog
package wdt_pkg;

  // ---------------------------------------------------------------------------
  // Register byte addresses
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADDR_LOAD    = 8'h00;  // Reload value, read/write
  localparam logic [7:0] ADDR_VALUE   = 8'h04;  // Current count, read only
  localparam logic [7:0] ADDR_CTRL    = 8'h08;  // Enables, read/write
  localparam logic [7:0] ADDR_INTCLR  = 8'h0c;  // Any write clears interrupt while unlocked
  localparam logic [7:0] ADDR_RIS     = 8'h10;  // Raw status, read only
  localparam logic [7:0] ADDR_MIS     = 8'h14;  // Masked status, read only
  localparam logic [7:0] ADDR_LOCK    = 8'h18;  // Lock control and state
  localparam int         ADDR_W       = 8;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int CTRL_INTEN_BIT = 0;  // Counter and interrupt enable
  localparam int CTRL_RESEN_BIT = 1;  // Reset on second timeout enable
  localparam int CTRL_STALL_BIT = 2;  // Stop counting under debug halt
  localparam int LOCK_BIT       = 0;  // Lock write value / lock state

  // ---------------------------------------------------------------------------
  // Values
  // ---------------------------------------------------------------------------
  localparam logic [31:0] LOAD_RESET  = 32'hffffffff;
  localparam logic [31:0] COUNT_ZERO  = 32'h00000000;
  localparam logic [31:0] COUNT_ONE   = 32'h00000001;
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;

endpackage

//--- verilog/wdt_cfg_if.sv
// Interface carrying configuration strobes between bus slave and watchdog core
`timescale 1ns/100ps
interface wdt_cfg_if;
  logic        load_wr;     // Reload value written
  logic [31:0] load_data;   // New reload value
  logic        enable_set;  // Enable counter and interrupt
  logic        resen_wr;    // Write reset enable
  logic        resen_data;  // New reset enable
  logic        stall_wr;    // Write stall enable
  logic        stall_data;  // New stall enable
  logic        int_clear;   // Clear pending interrupt
  logic        lock_wr;     // Write to lock register
  logic        lock_data;   // Engage (1) or release (0)
  logic [31:0] load_q;      // Stored reload value
  logic [31:0] count;       // Current count
  logic        enabled;     // Counter enabled
  logic        resen;       // Reset enable state
  logic        stall;       // Stall enable state
  logic        raw_int;     // Raw interrupt
  logic        locked;      // Lock state

  modport bus  (output load_wr, load_data, enable_set, resen_wr, resen_data, stall_wr, stall_data,
                int_clear, lock_wr, lock_data,
                input load_q, count, enabled, resen, stall, raw_int, locked);
  modport core (input load_wr, load_data, enable_set, resen_wr, resen_data, stall_wr, stall_data,
                int_clear, lock_wr, lock_data,
                output load_q, count, enabled, resen, stall, raw_int, locked);
endinterface

//--- verilog/wdt_axil_slave.sv
// AXI4-Lite register slave for the watchdog
`timescale 1ns/100ps
module wdt_axil_slave
  import wdt_pkg::*;
(
  input  wire logic              clk_in,         // System clock
  input  wire logic              resetn_in,      // Async reset, active low
  input  wire logic [ADDR_W-1:0] awaddr_in,      // Write address
  input  wire logic              awvalid_in,     // Write address valid
  output logic                   awready_out,    // Write address ready
  input  wire logic [31:0]       wdata_in,       // Write data
  input  wire logic [3:0]        wstrb_in,       // Write strobes
  input  wire logic              wvalid_in,      // Write data valid
  output logic                   wready_out,     // Write data ready
  output logic [1:0]             bresp_out,      // Write response
  output logic                   bvalid_out,     // Write response valid
  input  wire logic              bready_in,      // Write response ready
  input  wire logic [ADDR_W-1:0] araddr_in,      // Read address
  input  wire logic              arvalid_in,     // Read address valid
  output logic                   arready_out,    // Read address ready
  output logic [31:0]            rdata_out,      // Read data
  output logic [1:0]             rresp_out,      // Read response
  output logic                   rvalid_out,     // Read data valid
  input  wire logic              rready_in,      // Read data ready
  wdt_cfg_if.bus                 cfg             // Watchdog core side
);

  // ---------------------------------------------------------------------------
  // Write channel capture
  // ---------------------------------------------------------------------------
  logic              aw_held_q;
  logic              w_held_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              wr_go;
  logic              wr_hit;
  logic              wr_full;

  assign awready_out = !aw_held_q && !bvalid_out;
  assign wready_out  = !w_held_q && !bvalid_out;
  assign wr_go       = aw_held_q && w_held_q && !bvalid_out;
  assign wr_full     = (wstrb_q == 4'hf);

  // Hold address and data until both have arrived
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
    end
    else
    begin
      if (awvalid_in && awready_out)
      begin
        aw_held_q <= 1'b1;
        awaddr_q  <= awaddr_in;
      end
      else if (wr_go)
        aw_held_q <= 1'b0;
      if (wvalid_in && wready_out)
      begin
        w_held_q <= 1'b1;
        wdata_q  <= wdata_in;
        wstrb_q  <= wstrb_in;
      end
      else if (wr_go)
        w_held_q <= 1'b0;
    end
  end

  // Decode write; locked writes to configuration are dropped but answered OKAY
  always_comb
  begin
    cfg.load_wr    = 1'b0;
    cfg.enable_set = 1'b0;
    cfg.resen_wr   = 1'b0;
    cfg.stall_wr   = 1'b0;
    cfg.int_clear  = 1'b0;
    cfg.lock_wr    = 1'b0;
    wr_hit         = 1'b1;
    case (awaddr_q)
      ADDR_LOAD:   cfg.load_wr = wr_go && wr_full && !cfg.locked;
      ADDR_CTRL:
      begin
        cfg.enable_set = wr_go && wstrb_q[0] && wdata_q[CTRL_INTEN_BIT] && !cfg.locked;
        cfg.resen_wr   = wr_go && wstrb_q[0] && !cfg.locked;
        cfg.stall_wr   = wr_go && wstrb_q[0] && !cfg.locked;
      end
      ADDR_INTCLR: cfg.int_clear = wr_go && !cfg.locked;
      ADDR_LOCK:   cfg.lock_wr   = wr_go && wstrb_q[0];
      ADDR_VALUE, ADDR_RIS, ADDR_MIS: wr_hit = 1'b1;
      default:     wr_hit = 1'b0;
    endcase
  end

  assign cfg.load_data  = wdata_q;
  assign cfg.resen_data = wdata_q[CTRL_RESEN_BIT];
  assign cfg.stall_data = wdata_q[CTRL_STALL_BIT];
  assign cfg.lock_data  = wdata_q[LOCK_BIT];

  // Write response
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      bvalid_out <= 1'b0;
      bresp_out  <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid_out <= 1'b1;
      bresp_out  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bready_in)
      bvalid_out <= 1'b0;
  end

  // ---------------------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------------------
  assign arready_out = !rvalid_out;

  // Read mux, one cycle after address acceptance
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rvalid_out <= 1'b0;
      rdata_out  <= '0;
      rresp_out  <= RESP_OKAY;
    end
    else if (arvalid_in && arready_out)
    begin
      rvalid_out <= 1'b1;
      rresp_out  <= RESP_OKAY;
      rdata_out  <= '0;
      case (araddr_in)
        ADDR_LOAD:   rdata_out <= cfg.load_q;
        ADDR_VALUE:  rdata_out <= cfg.count;
        ADDR_CTRL:
        begin
          rdata_out[CTRL_INTEN_BIT] <= cfg.enabled;
          rdata_out[CTRL_RESEN_BIT] <= cfg.resen;
          rdata_out[CTRL_STALL_BIT] <= cfg.stall;
        end
        ADDR_INTCLR: rdata_out <= '0;
        ADDR_RIS:    rdata_out[0] <= cfg.raw_int;
        ADDR_MIS:    rdata_out[0] <= cfg.raw_int && cfg.enabled;
        ADDR_LOCK:   rdata_out[LOCK_BIT] <= cfg.locked;
        default:     rresp_out <= RESP_SLVERR;
      endcase
    end
    else if (rready_in)
      rvalid_out <= 1'b0;
  end

endmodule // wdt_axil_slave

//--- verilog/wdt_core.sv
// Watchdog counter, two-stage timeout, lock and debug stall logic
`timescale 1ns/100ps
module wdt_core
  import wdt_pkg::*;
(
  input  wire logic clk_in,         // System clock
  input  wire logic resetn_in,      // Async reset, active low
  input  wire logic debug_halt_in,  // Processor halted by debugger
  wdt_cfg_if.core   cfg,            // Configuration from bus slave
  output logic      irq_out,        // Interrupt to processor
  output logic      sys_reset_out   // Reset request to system
);

  logic [31:0] count_q;
  logic [31:0] load_q;
  logic        enabled_q;
  logic        resen_q;
  logic        stall_q;
  logic        raw_int_q;
  logic        locked_q;
  logic        sys_reset_q;
  logic        run;
  logic        timeout;

  // ---------------------------------------------------------------------------
  // Count control
  // ---------------------------------------------------------------------------
  assign run     = enabled_q && !(stall_q && debug_halt_in);
  assign timeout = run && (count_q == COUNT_ZERO);

  // Configuration registers; all inactive and unlocked after reset
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      load_q    <= LOAD_RESET;
      enabled_q <= 1'b0;
      resen_q   <= 1'b0;
      stall_q   <= 1'b0;
      locked_q  <= 1'b0;
    end
    else
    begin
      if (cfg.load_wr)
        load_q <= cfg.load_data;
      if (cfg.enable_set)
        enabled_q <= 1'b1;
      if (cfg.resen_wr)
        resen_q <= cfg.resen_data;
      if (cfg.stall_wr)
        stall_q <= cfg.stall_data;
      if (cfg.lock_wr)
        locked_q <= cfg.lock_data;
    end
  end

  // Down counter with reload on timeout, clear and load write
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      count_q <= LOAD_RESET;
    else if (cfg.load_wr)
      count_q <= cfg.load_data;
    else if (cfg.int_clear && !timeout)
      count_q <= load_q;
    else if (timeout)
      count_q <= load_q;
    else if (run)
      count_q <= count_q - COUNT_ONE;
  end

  // Sticky interrupt; a timeout in the clear cycle wins
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      raw_int_q <= 1'b0;
    else if (timeout || (cfg.load_wr && cfg.load_data == COUNT_ZERO && enabled_q))
      raw_int_q <= 1'b1;
    else if (cfg.int_clear)
      raw_int_q <= 1'b0;
  end

  // Second timeout with interrupt still pending asserts system reset
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      sys_reset_q <= 1'b0;
    else if (timeout && raw_int_q && resen_q)
      sys_reset_q <= 1'b1;
  end

  assign irq_out        = raw_int_q && enabled_q;
  assign sys_reset_out  = sys_reset_q;
  assign cfg.load_q     = load_q;
  assign cfg.count      = count_q;
  assign cfg.enabled    = enabled_q;
  assign cfg.resen      = resen_q;
  assign cfg.stall      = stall_q;
  assign cfg.raw_int    = raw_int_q;
  assign cfg.locked     = locked_q;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  a_count_decrement: assert property (@(posedge clk_in) disable iff (!resetn_in)
    run && count_q != COUNT_ZERO && !cfg.load_wr && !cfg.int_clear |=> count_q == $past(count_q) - COUNT_ONE)
    else $error("count did not decrement");
  a_first_timeout: assert property (@(posedge clk_in) disable iff (!resetn_in)
    timeout |=> raw_int_q)
    else $error("timeout did not raise interrupt");
  a_reload_timeout: assert property (@(posedge clk_in) disable iff (!resetn_in)
    timeout && !cfg.load_wr |=> count_q == $past(load_q))
    else $error("counter not reloaded after timeout");
  a_second_reset: assert property (@(posedge clk_in) disable iff (!resetn_in)
    timeout && raw_int_q && resen_q |=> sys_reset_out)
    else $error("second timeout missed reset");
  a_no_early_reset: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $rose(sys_reset_out) |-> $past(raw_int_q) && $past(resen_q))
    else $error("reset without pending interrupt");
  a_clear_reload: assert property (@(posedge clk_in) disable iff (!resetn_in)
    cfg.int_clear && !cfg.load_wr |=> count_q == $past(load_q))
    else $error("clear did not reload counter");
  a_load_write: assert property (@(posedge clk_in) disable iff (!resetn_in)
    cfg.load_wr |=> count_q == $past(cfg.load_data) && load_q == $past(cfg.load_data))
    else $error("load write not transferred");
  a_lock_blocks: assert property (@(posedge clk_in) disable iff (!resetn_in)
    locked_q && !enabled_q |=> !enabled_q)
    else $error("enable changed while locked");
  a_clear_irq: assert property (@(posedge clk_in) disable iff (!resetn_in)
    cfg.int_clear && !timeout && !cfg.load_wr |=> !irq_out)
    else $error("clear did not drop interrupt");
  a_stay_enabled: assert property (@(posedge clk_in) disable iff (!resetn_in)
    enabled_q |=> enabled_q)
    else $error("enable dropped");
  a_stall_holds: assert property (@(posedge clk_in) disable iff (!resetn_in)
    stall_q && debug_halt_in && !cfg.load_wr && !cfg.int_clear |=> $stable(count_q))
    else $error("counter moved under debug stall");

  c_first_timeout: cover property (@(posedge clk_in) disable iff (!resetn_in) timeout && !raw_int_q);
  c_reset_fired:   cover property (@(posedge clk_in) disable iff (!resetn_in) $rose(sys_reset_out));
  c_clear_pending: cover property (@(posedge clk_in) disable iff (!resetn_in) cfg.int_clear && raw_int_q);
  c_lock_engaged:  cover property (@(posedge clk_in) disable iff (!resetn_in) $rose(locked_q));

endmodule // wdt_core

//--- verilog/watchdog_two_stage_timer.sv
// Top level of the two-stage watchdog timer with AXI4-Lite registers
`timescale 1ns/100ps
// Functional notes
// - Timeout counter is 32 bits and counts down while enabled.
// - First zero of the enabled counter raises the interrupt.
// - Enabling the counter also enables the interrupt.
// - After first timeout the counter reloads from the load register.
// - Second zero with interrupt pending and reset enabled asserts system reset.
// - Clearing the interrupt reloads the counter and restarts counting.
// - Writing a new load value moves it into the counter at once.
// - Writing 1 to the lock register blocks configuration writes.
// - While locked, enabling counter or interrupt has no effect.
// - Lock status reads true when locked, false otherwise.
// - Interrupt clear removes the pending interrupt and drops the output.
// - Raw and masked interrupt status are both readable.
// - Status bit reads 1 when interrupt active, 0 when inactive.
// - Loading zero while the counter is enabled generates the interrupt immediately.
// - Load register reads back the reload value.
// - Interrupt has no control of its own; the counter enable bit also enables it, subject to lock.
// - Reset enable decides if second timeout resets; settable when unlocked.
// - With stall enabled, counting stops while the debugger halts the processor.
// - Unlock restores configuration write access.
// - Current count is readable at any time.
module watchdog_two_stage_timer
  import wdt_pkg::*;
(
  input  wire logic              clk_in,         // System clock, 100 MHz
  input  wire logic              resetn_in,      // Async reset, active low
  input  wire logic              debug_halt_in,  // Processor halted by debugger
  input  wire logic [ADDR_W-1:0] awaddr_in,      // Write address
  input  wire logic              awvalid_in,     // Write address valid
  output logic                   awready_out,    // Write address ready
  input  wire logic [31:0]       wdata_in,       // Write data
  input  wire logic [3:0]        wstrb_in,       // Write strobes
  input  wire logic              wvalid_in,      // Write data valid
  output logic                   wready_out,     // Write data ready
  output logic [1:0]             bresp_out,      // Write response
  output logic                   bvalid_out,     // Write response valid
  input  wire logic              bready_in,      // Write response ready
  input  wire logic [ADDR_W-1:0] araddr_in,      // Read address
  input  wire logic              arvalid_in,     // Read address valid
  output logic                   arready_out,    // Read address ready
  output logic [31:0]            rdata_out,      // Read data
  output logic [1:0]             rresp_out,      // Read response
  output logic                   rvalid_out,     // Read data valid
  input  wire logic              rready_in,      // Read data ready
  output logic                   irq_out,        // Interrupt to processor
  output logic                   sys_reset_out   // System reset request
);

  // ---------------------------------------------------------------------------
  // Internal configuration carrier
  // ---------------------------------------------------------------------------
  wdt_cfg_if cfg ();

  // Register slave
  wdt_axil_slave u_slave (
    .clk_in      (clk_in),
    .resetn_in   (resetn_in),
    .awaddr_in   (awaddr_in),
    .awvalid_in  (awvalid_in),
    .awready_out (awready_out),
    .wdata_in    (wdata_in),
    .wstrb_in    (wstrb_in),
    .wvalid_in   (wvalid_in),
    .wready_out  (wready_out),
    .bresp_out   (bresp_out),
    .bvalid_out  (bvalid_out),
    .bready_in   (bready_in),
    .araddr_in   (araddr_in),
    .arvalid_in  (arvalid_in),
    .arready_out (arready_out),
    .rdata_out   (rdata_out),
    .rresp_out   (rresp_out),
    .rvalid_out  (rvalid_out),
    .rready_in   (rready_in),
    .cfg         (cfg.bus)
  );

  // Watchdog counter core
  wdt_core u_core (
    .clk_in        (clk_in),
    .resetn_in     (resetn_in),
    .debug_halt_in (debug_halt_in),
    .cfg           (cfg.core),
    .irq_out       (irq_out),
    .sys_reset_out (sys_reset_out)
  );

  // ---------------------------------------------------------------------------
  // Top-level checks
  // ---------------------------------------------------------------------------
  a_lock_status: assert property (@(posedge clk_in) disable iff (!resetn_in)
    cfg.lock_wr |=> cfg.locked == $past(cfg.lock_data))
    else $error("lock state does not follow write");
  a_reset_idle: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $rose(resetn_in) |-> !cfg.enabled && !cfg.locked && !irq_out)
    else $error("state active after reset");
  a_irq_masked: assert property (@(posedge clk_in) disable iff (!resetn_in)
    arvalid_in && arready_out && araddr_in == ADDR_MIS |=> rdata_out[0] == $past(irq_out))
    else $error("masked status does not match interrupt output");
  a_zero_load: assert property (@(posedge clk_in) disable iff (!resetn_in)
    cfg.load_wr && cfg.load_data == COUNT_ZERO && cfg.enabled |=> cfg.raw_int)
    else $error("zero load did not interrupt");
  a_bus_answer: assert property (@(posedge clk_in) disable iff (!resetn_in)
    arvalid_in && arready_out |=> rvalid_out)
    else $error("read not answered in one cycle");

  c_zero_load: cover property (@(posedge clk_in) disable iff (!resetn_in) cfg.load_wr && cfg.load_data == COUNT_ZERO);

endmodule // watchdog_two_stage_timer

//--- test/watchdog_two_stage_timer_tb.sv
// Self-checking bench for the two-stage watchdog timer
`timescale 1ns/100ps
module watchdog_two_stage_timer_tb;
  import wdt_pkg::*;
  logic        clk_in = 1'b0, resetn_in = 1'b0, debug_halt_in = 1'b0, got;
  logic [7:0]  awaddr_in = 8'h00, araddr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0, rdata_out, seed = 32'hddc1b0f2, ld;
  logic [3:0]  wstrb_in = 4'hf;
  logic        awvalid_in = 1'b0, wvalid_in = 1'b0, bready_in = 1'b0, arvalid_in = 1'b0, rready_in = 1'b0;
  logic        awready_out, wready_out, bvalid_out, arready_out, rvalid_out, irq_out, sys_reset_out;
  logic [1:0]  bresp_out, rresp_out;
  logic [33:0] q[$];
  int          err_total = 0, n_checks = 0;

  // 100 MHz clock
  always #5 clk_in = ~clk_in;

  watchdog_two_stage_timer i_dut (.clk_in(clk_in), .resetn_in(resetn_in), .debug_halt_in(debug_halt_in),
    .awaddr_in(awaddr_in), .awvalid_in(awvalid_in), .awready_out(awready_out), .wdata_in(wdata_in),
    .wstrb_in(wstrb_in), .wvalid_in(wvalid_in), .wready_out(wready_out), .bresp_out(bresp_out),
    .bvalid_out(bvalid_out), .bready_in(bready_in), .araddr_in(araddr_in), .arvalid_in(arvalid_in),
    .arready_out(arready_out), .rdata_out(rdata_out), .rresp_out(rresp_out), .rvalid_out(rvalid_out),
    .rready_in(rready_in), .irq_out(irq_out), .sys_reset_out(sys_reset_out));

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Waits for arready (0), rvalid (1) or bvalid (2), sampled before the edge
  task automatic hs(input int s);
    logic t;
    do
    begin
      @(negedge clk_in);
      t = (s == 0) ? arready_out : (s == 1) ? rvalid_out : bvalid_out;
      @(posedge clk_in);
    end while (!t);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    logic ta, tw;
    q.push_back({r, 32'h0});
    awaddr_in <= a;
    wdata_in <= d;
    awvalid_in <= 1'b1;
    wvalid_in <= 1'b1;
    ta = 1'b0;
    tw = 1'b0;
    while (!(ta && tw))
    begin
      @(negedge clk_in);
      ta |= awready_out;
      tw |= wready_out;
      @(posedge clk_in);
      if (ta) awvalid_in <= 1'b0;
      if (tw) wvalid_in <= 1'b0;
    end
    bready_in <= 1'b1;
    hs(2);
    bready_in <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = RESP_OKAY);
    q.push_back({r, e});
    araddr_in <= a;
    arvalid_in <= 1'b1;
    hs(0);
    arvalid_in <= 1'b0;
    rready_in <= 1'b1;
    hs(1);
    rready_in <= 1'b0;
  endtask

  // Sets got when irq (0) or system reset (1) is seen within n cycles
  task automatic wt(input bit s, input int n);
    got = 1'b0;
    for (int i = 0; i < n && !got; i++)
    begin
      @(negedge clk_in);
      got = s ? sys_reset_out : irq_out;
    end
    @(posedge clk_in);
  endtask

  task automatic rst();
    resetn_in <= 1'b0;
    repeat (16) @(posedge clk_in);
    resetn_in <= 1'b1;
    @(posedge clk_in);
  endtask

  // Compare each bus answer with the oldest queued note
  always @(posedge clk_in)
  begin
    if (rvalid_out && rready_in)
      chk("read", {rresp_out, (rresp_out == RESP_OKAY) ? rdata_out : 32'h0}, q.pop_front());
    if (bvalid_out && bready_in)
      chk("bresp", {bresp_out, 32'h0}, q.pop_front());
  end

  // ---------------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------------
  initial
  begin
    rst();
    rd(ADDR_LOAD, LOAD_RESET);
    rd(ADDR_VALUE, LOAD_RESET);
    rd(ADDR_CTRL, 32'h0);
    rd(ADDR_LOCK, 32'h0);
    rd(ADDR_RIS, 32'h0);
    rd(8'h1c, 32'h0, RESP_SLVERR);
    wr(8'h20, 32'h0, RESP_SLVERR);
    $display("reset test done");
    wr(ADDR_LOCK, 32'h1);
    rd(ADDR_LOCK, 32'h1);
    wr(ADDR_LOAD, 32'h5);
    wr(ADDR_CTRL, 32'h1);
    rd(ADDR_LOAD, LOAD_RESET);
    rd(ADDR_CTRL, 32'h0);
    wr(ADDR_LOCK, 32'h0);
    rd(ADDR_LOCK, 32'h0);
    $display("lock test done");
    seed = xs(seed);
    ld = {27'h0, seed[4:0]} + 32'h10;
    debug_halt_in <= 1'b1;
    wr(ADDR_CTRL, 32'h7);
    rd(ADDR_CTRL, 32'h7);
    wr(ADDR_LOAD, ld);
    rd(ADDR_LOAD, ld);
    rd(ADDR_VALUE, ld);
    wr(ADDR_CTRL, 32'h6);
    rd(ADDR_CTRL, 32'h7);
    debug_halt_in <= 1'b0;
    wt(1'b0, 64);
    chk("irq first", got, 34'h1);
    rd(ADDR_RIS, 32'h1);
    rd(ADDR_MIS, 32'h1);
    wr(ADDR_INTCLR, 32'h0);
    rd(ADDR_RIS, 32'h0);
    chk("early reset", sys_reset_out, 34'h0);
    wt(1'b0, 64);
    chk("irq again", got, 34'h1);
    wt(1'b1, 64);
    chk("sys reset", got, 34'h1);
    $display("timeout test done");
    rst();
    debug_halt_in <= 1'b1;
    wr(ADDR_CTRL, 32'h3);
    wr(ADDR_CTRL, 32'h1);
    rd(ADDR_CTRL, 32'h1);
    wr(ADDR_LOAD, 32'h0);
    wt(1'b0, 4);
    chk("irq zero load", got, 34'h1);
    wr(ADDR_INTCLR, 32'h0);
    rd(ADDR_RIS, 32'h1);
    wt(1'b1, 16);
    chk("reset disabled", got, 34'h0);
    $display("zero load test done");
    final_report();
  end

  // Cuts a hang short
  initial
  begin
    #200000;
    err_total++;
    final_report();
  end
endmodule // watchdog_two_stage_timer_tb
